// ### core/tpc_pkg.sv
// Purpose: shared constants and types for the throttle position controller
// Assumes: avalon-mm slave, 32-bit data, byte addresses, one word per register
// Notes: positions, voltages and gains are 16-bit fixed-point words
package tpc_pkg;
   localparam int DW = 16;
   localparam int AW = 8;
   // control period timing
   localparam int CLK_HZ = 10_000_000;
   localparam int CTRL_PERIOD_US = 1000;
   localparam int CTRL_PERIOD_CYCLES = CTRL_PERIOD_US * (CLK_HZ / 1_000_000);
   // fixed-point scaling
   localparam int GAIN_FRAC = 8;
   localparam int RES_FRAC = 8;
   localparam logic [15:0] DRIVE_CURRENT_LIMIT = 16'h0008;
   localparam logic signed [31:0] WORD_MAX = 32'sh0000_7fff;
   localparam logic signed [31:0] WORD_MIN = -32'sh0000_8000;
   localparam logic signed [31:0] ACC_MAX = 32'sh3fff_ffff;
   localparam logic signed [31:0] ACC_MIN = -32'sh4000_0000;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_SETPOINT = 8'h08;
   localparam logic [7:0] REG_LEAD = 8'h0c;
   localparam logic [7:0] REG_LAG = 8'h10;
   localparam logic [7:0] REG_KP_UP = 8'h14;
   localparam logic [7:0] REG_TI_UP = 8'h18;
   localparam logic [7:0] REG_TD_UP = 8'h1c;
   localparam logic [7:0] REG_KP_LO = 8'h20;
   localparam logic [7:0] REG_TI_LO = 8'h24;
   localparam logic [7:0] REG_TD_LO = 8'h28;
   localparam logic [7:0] REG_LH_CFG = 8'h2c;
   localparam logic [7:0] REG_LH_BAND = 8'h30;
   localparam logic [7:0] REG_LH_COMP = 8'h34;
   localparam logic [7:0] REG_LH_LAG = 8'h38;
   localparam logic [7:0] REG_ST_COMP = 8'h3c;
   localparam logic [7:0] REG_ST_LAG = 8'h40;
   localparam logic [7:0] REG_RES = 8'h44;
   localparam logic [7:0] REG_THRESH = 8'h48;
   localparam logic [7:0] REG_LH_USE = 8'h4c;
   localparam logic [7:0] REG_DRIVE = 8'h50;
   localparam logic [7:0] REG_LH_VOLT = 8'h54;
   localparam logic [7:0] REG_ST_VOLT = 8'h58;
   // field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int STAT_FAULT_BIT = 0;
   localparam int STAT_CAL_BIT = 1;
   localparam int STAT_BAND_BIT = 2;
   localparam int SHIFT_W = 4;
   typedef enum logic [5:0] {
      TPC_IDLE = 6'b000001,
      TPC_SHAPE = 6'b000010,
      TPC_PID = 6'b000100,
      TPC_COMP = 6'b001000,
      TPC_LIMIT = 6'b010000,
      TPC_FAULT = 6'b100000
   } tpc_step_t;
   typedef struct packed {
      logic [AW-1:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } tpc_av_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } tpc_av_rsp_t;
   typedef struct packed {
      logic signed [DW-1:0] primary;
      logic signed [DW-1:0] secondary;
   } tpc_pos_t;
endpackage

// ### core/tpc_throttle_ctrl.sv
// Purpose: closed-loop throttle plate position controller, one h-bridge channel
// Assumes: position samples come from logic on sys_clk; calibration is external
// Notes: lag times are shift exponents per control period, 0 = no filtering; lead and derivative times are multipliers
// Function
// - setpoint passes lead then lag shaping before the pid loop
// - setpoint above limp-home selects upper-side gain and times
// - setpoint at or below limp-home selects lower-side gain and times
// - zero integral time disables integral; smaller time means stronger action
// - zero derivative time disables derivative; larger time means stronger action
// - limp-home compensation updates only while setpoint is within band
// - in limp-home region a signed compensation voltage adds to pid output
// - limp-home compensation passes a first-order lag with configurable time
// - outside limp-home vicinity stiction voltage adds, signed by setpoint minus primary
// - stiction compensation passes a first-order lag with configurable time
// - fault asserts when primary and secondary differ by more than threshold
// - fault is not latched; re-evaluated each period from latest readings
// - winding resistance sets the symmetric limit on the drive output
// - configured limp-home used until calibration supplies a new value
// - in-use values read back equal to configured ones before calibration
`timescale 1ns/1ps
module tpc_throttle_ctrl #(
   parameter int PERIOD_CYCLES = tpc_pkg::CTRL_PERIOD_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire tpc_pkg::tpc_av_req_t av_req,
   output tpc_pkg::tpc_av_rsp_t av_rsp,
   input wire tpc_pkg::tpc_pos_t position,
   input wire logic cal_valid,
   input wire logic signed [tpc_pkg::DW-1:0] cal_limp_home,
   output logic signed [tpc_pkg::DW-1:0] motor_drive,
   output logic position_disagree_fault,
   output logic signed [tpc_pkg::DW-1:0] limp_home_position_in_use,
   output logic period_done
);
   typedef struct packed {
      logic ack;
      logic [31:0] readdata;
      logic enable;
      logic signed [15:0] position_setpoint;
      logic [15:0] setpoint_lead_time;
      logic [3:0] setpoint_lag_time;
      logic [15:0] upper_side_prop_gain;
      logic [3:0] upper_side_integral_time;
      logic [15:0] upper_side_derivative_time;
      logic [15:0] lower_side_prop_gain;
      logic [3:0] lower_side_integral_time;
      logic [15:0] lower_side_derivative_time;
      logic signed [15:0] limp_home_position_config;
      logic [15:0] limp_home_band;
      logic signed [15:0] limp_home_comp_value;
      logic [3:0] limp_home_comp_lag_time;
      logic [15:0] stiction_comp_voltage;
      logic [3:0] stiction_comp_lag_time;
      logic [15:0] winding_resistance;
      logic [15:0] position_disagree_threshold;
      logic cal_used;
      logic signed [15:0] lh_cal;
      logic [15:0] timer;
      tpc_pkg::tpc_step_t step;
      logic signed [15:0] sp_prev;
      logic signed [15:0] shaped;
      logic signed [15:0] err_prev;
      logic signed [31:0] integ;
      logic signed [31:0] pid;
      logic in_band;
      logic signed [15:0] limp_home_comp_voltage;
      logic signed [15:0] stiction_comp_value;
      logic signed [15:0] drive;
      logic fault;
      logic done;
   } tpc_state_t;

   tpc_state_t s;
   tpc_state_t next_s;

   function automatic logic signed [31:0] sx(input logic [15:0] v);
      return {{16{v[15]}}, v};
   endfunction

   function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                input logic signed [31:0] lim);
      if (v > lim)
      begin
         return lim;
      end
      if (v < -lim)
      begin
         return -lim;
      end
      return v;
   endfunction

   function automatic logic signed [15:0] to_word(input logic signed [31:0] v);
      logic signed [31:0] c;
      c = (v < tpc_pkg::WORD_MIN) ? tpc_pkg::WORD_MIN : v;
      c = (c > tpc_pkg::WORD_MAX) ? tpc_pkg::WORD_MAX : c;
      return c[15:0];
   endfunction

   function automatic logic signed [31:0] mag(input logic signed [31:0] v);
      return (v < 0) ? -v : v;
   endfunction

   // first-order lag: step toward target by 1/2^t of the gap
   function automatic logic signed [15:0] lag(input logic signed [15:0] y,
                                              input logic signed [31:0] x,
                                              input logic [3:0] t);
      logic signed [31:0] gap;
      gap = x - sx(y);
      return to_word(sx(y) + (gap >>> t));
   endfunction

   logic signed [15:0] lh_use;
   logic [31:0] rd_mux;
   logic [7:0] word_addr;
   logic req;
   logic signed [31:0] err;
   logic signed [31:0] lead_out;
   logic signed [31:0] pterm;
   logic signed [31:0] iterm;
   logic signed [31:0] dterm;
   logic signed [47:0] prod;
   logic signed [31:0] tgt;
   logic signed [31:0] sum;
   logic signed [31:0] limit;
   logic [47:0] lim_prod;
   logic upper;
   logic [15:0] kp;
   logic [3:0] ti;
   logic [15:0] td;

   assign lh_use = s.cal_used ? s.lh_cal : s.limp_home_position_config;
   assign req = av_req.read | av_req.write;
   assign word_addr = {av_req.address[7:2], 2'b00};
   assign av_rsp.waitrequest = req & ~s.ack;
   assign av_rsp.readdata = s.readdata;
   assign motor_drive = s.drive;
   assign position_disagree_fault = s.fault;
   assign limp_home_position_in_use = lh_use;
   assign period_done = s.done;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (word_addr)
         tpc_pkg::REG_CTRL: rd_mux[tpc_pkg::CTRL_ENABLE_BIT] = s.enable;
         tpc_pkg::REG_STATUS:
         begin
            rd_mux[tpc_pkg::STAT_FAULT_BIT] = s.fault;
            rd_mux[tpc_pkg::STAT_CAL_BIT] = s.cal_used;
            rd_mux[tpc_pkg::STAT_BAND_BIT] = s.in_band;
         end
         tpc_pkg::REG_SETPOINT: rd_mux[15:0] = s.position_setpoint;
         tpc_pkg::REG_LEAD: rd_mux[15:0] = s.setpoint_lead_time;
         tpc_pkg::REG_LAG: rd_mux[3:0] = s.setpoint_lag_time;
         tpc_pkg::REG_KP_UP: rd_mux[15:0] = s.upper_side_prop_gain;
         tpc_pkg::REG_TI_UP: rd_mux[3:0] = s.upper_side_integral_time;
         tpc_pkg::REG_TD_UP: rd_mux[15:0] = s.upper_side_derivative_time;
         tpc_pkg::REG_KP_LO: rd_mux[15:0] = s.lower_side_prop_gain;
         tpc_pkg::REG_TI_LO: rd_mux[3:0] = s.lower_side_integral_time;
         tpc_pkg::REG_TD_LO: rd_mux[15:0] = s.lower_side_derivative_time;
         tpc_pkg::REG_LH_CFG: rd_mux[15:0] = s.limp_home_position_config;
         tpc_pkg::REG_LH_BAND: rd_mux[15:0] = s.limp_home_band;
         tpc_pkg::REG_LH_COMP: rd_mux[15:0] = s.limp_home_comp_value;
         tpc_pkg::REG_LH_LAG: rd_mux[3:0] = s.limp_home_comp_lag_time;
         tpc_pkg::REG_ST_COMP: rd_mux[15:0] = s.stiction_comp_voltage;
         tpc_pkg::REG_ST_LAG: rd_mux[3:0] = s.stiction_comp_lag_time;
         tpc_pkg::REG_RES: rd_mux[15:0] = s.winding_resistance;
         tpc_pkg::REG_THRESH: rd_mux[15:0] = s.position_disagree_threshold;
         tpc_pkg::REG_LH_USE: rd_mux[15:0] = lh_use;
         tpc_pkg::REG_DRIVE: rd_mux[15:0] = s.drive;
         tpc_pkg::REG_LH_VOLT: rd_mux[15:0] = s.limp_home_comp_voltage;
         tpc_pkg::REG_ST_VOLT: rd_mux[15:0] = s.stiction_comp_value;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      next_s = s;
      err = 32'sh0;
      lead_out = 32'sh0;
      pterm = 32'sh0;
      iterm = 32'sh0;
      dterm = 32'sh0;
      prod = 48'sh0;
      tgt = 32'sh0;
      sum = 32'sh0;
      limit = 32'sh0;
      lim_prod = 48'h0;
      upper = s.position_setpoint > lh_use;
      kp = upper ? s.upper_side_prop_gain : s.lower_side_prop_gain;
      ti = upper ? s.upper_side_integral_time : s.lower_side_integral_time;
      td = upper ? s.upper_side_derivative_time : s.lower_side_derivative_time;
      next_s.done = 1'b0;
      // one wait cycle, then the access completes
      next_s.ack = req & ~s.ack;
      if (req & ~s.ack)
      begin
         next_s.readdata = av_req.read ? rd_mux : 32'h0000_0000;
      end
      if (av_req.write & s.ack)
      begin
         case (word_addr)
            tpc_pkg::REG_CTRL: next_s.enable = av_req.writedata[tpc_pkg::CTRL_ENABLE_BIT];
            tpc_pkg::REG_SETPOINT: next_s.position_setpoint = av_req.writedata[15:0];
            tpc_pkg::REG_LEAD: next_s.setpoint_lead_time = av_req.writedata[15:0];
            tpc_pkg::REG_LAG: next_s.setpoint_lag_time = av_req.writedata[3:0];
            tpc_pkg::REG_KP_UP: next_s.upper_side_prop_gain = av_req.writedata[15:0];
            tpc_pkg::REG_TI_UP: next_s.upper_side_integral_time = av_req.writedata[3:0];
            tpc_pkg::REG_TD_UP: next_s.upper_side_derivative_time = av_req.writedata[15:0];
            tpc_pkg::REG_KP_LO: next_s.lower_side_prop_gain = av_req.writedata[15:0];
            tpc_pkg::REG_TI_LO: next_s.lower_side_integral_time = av_req.writedata[3:0];
            tpc_pkg::REG_TD_LO: next_s.lower_side_derivative_time = av_req.writedata[15:0];
            tpc_pkg::REG_LH_CFG: next_s.limp_home_position_config = av_req.writedata[15:0];
            tpc_pkg::REG_LH_BAND: next_s.limp_home_band = av_req.writedata[15:0];
            tpc_pkg::REG_LH_COMP: next_s.limp_home_comp_value = av_req.writedata[15:0];
            tpc_pkg::REG_LH_LAG: next_s.limp_home_comp_lag_time = av_req.writedata[3:0];
            tpc_pkg::REG_ST_COMP: next_s.stiction_comp_voltage = av_req.writedata[15:0];
            tpc_pkg::REG_ST_LAG: next_s.stiction_comp_lag_time = av_req.writedata[3:0];
            tpc_pkg::REG_RES: next_s.winding_resistance = av_req.writedata[15:0];
            tpc_pkg::REG_THRESH: next_s.position_disagree_threshold = av_req.writedata[15:0];
            default: next_s.enable = s.enable;
         endcase
      end
      if (cal_valid)
      begin
         next_s.cal_used = 1'b1;
         next_s.lh_cal = cal_limp_home;
      end
      case (s.step)
         tpc_pkg::TPC_IDLE:
         begin
            if (s.timer >= 16'(PERIOD_CYCLES - 1))
            begin
               next_s.timer = 16'h0000;
               next_s.step = tpc_pkg::TPC_SHAPE;
            end
            else
            begin
               next_s.timer = s.timer + 16'h0001;
            end
         end
         tpc_pkg::TPC_SHAPE:
         begin
            // lead adds scaled setpoint change, lag then smooths the result
            prod = 48'(sx(s.position_setpoint) - sx(s.sp_prev)) * $signed({32'h0, s.setpoint_lead_time});
            lead_out = sx(s.position_setpoint) + clamp(prod[31:0], tpc_pkg::ACC_MAX);
            next_s.shaped = lag(s.shaped, sx(to_word(lead_out)), s.setpoint_lag_time);
            next_s.sp_prev = s.position_setpoint;
            next_s.timer = s.timer + 16'h0001;
            next_s.step = tpc_pkg::TPC_PID;
         end
         tpc_pkg::TPC_PID:
         begin
            err = sx(to_word(sx(s.shaped) - sx(position.primary)));
            prod = 48'(err) * $signed({32'h0, kp});
            // drop the gain's fraction bits; err times gain fits well inside 40 bits
            pterm = clamp(prod[31+tpc_pkg::GAIN_FRAC:tpc_pkg::GAIN_FRAC], tpc_pkg::ACC_MAX);
            if (ti == 4'h0)
            begin
               next_s.integ = 32'sh0;
            end
            else
            begin
               next_s.integ = clamp(s.integ + err, tpc_pkg::ACC_MAX);
               iterm = next_s.integ >>> ti;
            end
            if (td != 16'h0000)
            begin
               prod = 48'(err - sx(s.err_prev)) * $signed({32'h0, td});
               dterm = clamp(prod[31:0], tpc_pkg::ACC_MAX);
            end
            next_s.err_prev = err[15:0];
            next_s.pid = clamp(pterm + iterm + dterm, tpc_pkg::ACC_MAX);
            next_s.timer = s.timer + 16'h0001;
            next_s.step = tpc_pkg::TPC_COMP;
         end
         tpc_pkg::TPC_COMP:
         begin
            next_s.in_band = mag(sx(s.position_setpoint) - sx(lh_use)) <=
                             $signed({16'h0, s.limp_home_band});
            if (next_s.in_band)
            begin
               // opening force above limp-home, closing force below
               tgt = upper ? mag(sx(s.limp_home_comp_value))
                           : -mag(sx(s.limp_home_comp_value));
               next_s.limp_home_comp_voltage = lag(s.limp_home_comp_voltage, tgt,
                                                   s.limp_home_comp_lag_time);
            end
            tgt = 32'sh0;
            if (mag(sx(position.primary) - sx(lh_use)) > $signed({16'h0, s.limp_home_band}))
            begin
               if (s.position_setpoint > position.primary)
               begin
                  tgt = $signed({16'h0, s.stiction_comp_voltage});
               end
               else if (s.position_setpoint < position.primary)
               begin
                  tgt = -$signed({16'h0, s.stiction_comp_voltage});
               end
            end
            next_s.stiction_comp_value = lag(s.stiction_comp_value, tgt,
                                             s.stiction_comp_lag_time);
            next_s.timer = s.timer + 16'h0001;
            next_s.step = tpc_pkg::TPC_LIMIT;
         end
         tpc_pkg::TPC_LIMIT:
         begin
            sum = s.pid + sx(s.stiction_comp_value);
            if (s.in_band)
            begin
               sum = sum + sx(s.limp_home_comp_voltage);
            end
            // zero resistance gives zero drive, a safe default before setup
            lim_prod = 48'(s.winding_resistance) * 48'(tpc_pkg::DRIVE_CURRENT_LIMIT);
            limit = $signed({8'h0, lim_prod[23+tpc_pkg::RES_FRAC:tpc_pkg::RES_FRAC]});
            limit = (limit > tpc_pkg::WORD_MAX) ? tpc_pkg::WORD_MAX : limit;
            next_s.drive = s.enable ? to_word(clamp(sum, limit)) : 16'sh0000;
            next_s.timer = s.timer + 16'h0001;
            next_s.step = tpc_pkg::TPC_FAULT;
         end
         tpc_pkg::TPC_FAULT:
         begin
            // recomputed every period, never held
            next_s.fault = mag(sx(position.secondary) - sx(position.primary)) >
                           $signed({16'h0, s.position_disagree_threshold});
            next_s.done = 1'b1;
            next_s.timer = s.timer + 16'h0001;
            next_s.step = tpc_pkg::TPC_IDLE;
         end
         default:
         begin
            next_s.step = tpc_pkg::TPC_IDLE;
            next_s.timer = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s <= '0;
         s.step <= tpc_pkg::TPC_IDLE;
      end
      else
      begin
         s <= next_s;
      end
   end
endmodule

// ### sim/tpc_throttle_ctrl_properties.sv
// Purpose: port-level checks for the throttle position controller
// Assumes: the bus master holds each request until waitrequest is low
// Notes: register contents and loop arithmetic are judged by the bench
`timescale 1ns/1ps
module tpc_throttle_ctrl_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire tpc_pkg::tpc_av_req_t av_req,
   input wire tpc_pkg::tpc_av_rsp_t av_rsp,
   input wire logic cal_valid,
   input wire logic signed [tpc_pkg::DW-1:0] cal_limp_home,
   input wire logic signed [tpc_pkg::DW-1:0] motor_drive,
   input wire logic position_disagree_fault,
   input wire logic signed [tpc_pkg::DW-1:0] limp_home_position_in_use,
   input wire logic period_done
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic req = av_req.read | av_req.write;
   logic cal_seen;
   // calibration is sticky until reset, so later config writes must not show
   always_ff @(posedge sys_clk)
   begin
      cal_seen <= rst ? 1'b0 : (cal_seen | cal_valid);
   end
   a_wait_first: assert property (req && !$past(req) |-> av_rsp.waitrequest)
      else $error("waitrequest low on first cycle of a request");
   a_wait_one: assert property (req && av_rsp.waitrequest |=> !av_rsp.waitrequest)
      else $error("request waited more than one cycle");
   a_idle_nowait: assert property (!req |-> !av_rsp.waitrequest)
      else $error("waitrequest high while idle");
   a_fault_period: assert property ($changed(position_disagree_fault) |-> period_done)
      else $error("fault changed outside the fault step");
   a_drive_step: assert property ($changed(motor_drive) |=> period_done)
      else $error("drive changed outside the limit step");
   a_done_gap: assert property (period_done |=> !period_done [*4])
      else $error("period pulses too close");
   a_cal_take: assert property (cal_valid |=> limp_home_position_in_use == $past(cal_limp_home))
      else $error("calibrated limp-home not in use");
   a_cal_keep: assert property (cal_seen && !cal_valid |=> $stable(limp_home_position_in_use))
      else $error("limp-home moved after calibration");
endmodule
bind tpc_throttle_ctrl tpc_throttle_ctrl_chk tpc_throttle_ctrl_chk_i (
   .sys_clk(sys_clk),
   .rst(rst),
   .av_req(av_req),
   .av_rsp(av_rsp),
   .cal_valid(cal_valid),
   .cal_limp_home(cal_limp_home),
   .motor_drive(motor_drive),
   .position_disagree_fault(position_disagree_fault),
   .limp_home_position_in_use(limp_home_position_in_use),
   .period_done(period_done)
);

// ### sim/tpc_motor_model.sv
// Purpose: throttle motor and redundant position sensors behind the controller
// Assumes: plate moves once per control period, in proportion to the drive
// Notes: coarse movement so a clipped drive barely shifts the plate
`timescale 1ns/1ps
module tpc_motor_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic signed [tpc_pkg::DW-1:0] motor_drive,
   input wire logic period_done,
   input wire logic signed [tpc_pkg::DW-1:0] skew,
   output tpc_pkg::tpc_pos_t position
);
   logic signed [tpc_pkg::DW-1:0] plate;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         plate <= 16'sh0000;
      else if (period_done)
         plate <= plate + (motor_drive >>> 3);
   end
   // second sensor offset on command, to provoke disagreement
   assign position.primary = plate;
   assign position.secondary = plate + skew;
endmodule

// ### sim/testbench.sv
// Purpose: self-checking bench for the throttle position controller
// Assumes: short control period; writes land in the idle part of a period
// Notes: expected drives follow from gains, limits and lag shifts set here
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   tpc_pkg::tpc_av_req_t req = '0;
   tpc_pkg::tpc_av_rsp_t rsp;
   tpc_pkg::tpc_pos_t pos;
   logic cal_valid = 1'b0;
   logic signed [15:0] cal_lh = 16'sh0000;
   logic signed [15:0] skew = 16'sh0000;
   logic signed [15:0] drive;
   logic signed [15:0] in_use;
   logic fault;
   logic done;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #50 sys_clk = ~sys_clk;
   tpc_throttle_ctrl #(.PERIOD_CYCLES(40)) tpc_throttle_ctrl_i (.sys_clk(sys_clk), .rst(rst),
      .av_req(req), .av_rsp(rsp), .position(pos), .cal_valid(cal_valid),
      .cal_limp_home(cal_lh), .motor_drive(drive), .position_disagree_fault(fault),
      .limp_home_position_in_use(in_use), .period_done(done));
   tpc_motor_model tpc_motor_model_i (.sys_clk(sys_clk), .rst(rst), .motor_drive(drive),
      .period_done(done), .skew(skew), .position(pos));
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge; data taken there
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      req.address <= a;
      req.read <= !w;
      req.write <= w;
      req.writedata <= d;
      @(posedge sys_clk);
      while (rsp.waitrequest !== 1'b0)
         @(posedge sys_clk);
      q = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(q & m, e);
   endtask
   task automatic per(input int n);
      repeat (n)
      begin
         @(negedge sys_clk);
         while (done !== 1'b1)
            @(negedge sys_clk);
         @(posedge sys_clk);
      end
   endtask
   task automatic sp(input logic [15:0] v, input int n, input logic [15:0] e);
      wr(tpc_pkg::REG_SETPOINT, {16'h0000, v});
      per(n);
      chk({16'h0000, drive}, {16'h0000, e});
   endtask
   task automatic t_regs();
      rd(tpc_pkg::REG_DRIVE, 32'hffff_ffff, 32'h0000_0000);
      rd(8'h7c, 32'hffff_ffff, 32'h0000_0000);
      wr(tpc_pkg::REG_DRIVE, 32'h0000_1234);
      rd(tpc_pkg::REG_DRIVE, 32'hffff_ffff, 32'h0000_0000);
      wr(tpc_pkg::REG_LH_CFG, 32'h0000_0100);
      rd(tpc_pkg::REG_LH_USE, 32'hffff_ffff, 32'h0000_0100);
      chk({16'h0000, in_use}, 32'h0000_0100);
   endtask
   task automatic t_side();
      wr(tpc_pkg::REG_CTRL, 32'h0000_0001);
      wr(tpc_pkg::REG_RES, 32'h0000_0100);
      wr(tpc_pkg::REG_LH_BAND, 32'h0000_0010);
      wr(tpc_pkg::REG_KP_UP, 32'h0000_0100);
      sp(16'h0100, 2, 16'h0000);
      sp(16'h0101, 2, 16'h0008);
      wr(tpc_pkg::REG_KP_LO, 32'h0000_0100);
      sp(16'hff00, 2, 16'hfff8);
      wr(tpc_pkg::REG_KP_LO, 32'h0000_0000);
      wr(tpc_pkg::REG_KP_UP, 32'h0000_0000);
   endtask
   task automatic t_pid();
      wr(tpc_pkg::REG_TI_UP, 32'h0000_0001);
      sp(16'h1000, 2, 16'h0008);
      wr(tpc_pkg::REG_TI_UP, 32'h0000_0000);
      per(2);
      chk({16'h0000, drive}, 32'h0000_0000);
      wr(tpc_pkg::REG_TD_UP, 32'h0000_0001);
      per(1);
      sp(16'h1100, 1, 16'h0008);
      wr(tpc_pkg::REG_TD_UP, 32'h0000_0000);
      sp(16'h1100, 2, 16'h0000);
   endtask
   task automatic t_comp();
      wr(tpc_pkg::REG_ST_COMP, 32'h0000_0005);
      sp(16'h1000, 2, 16'h0005);
      sp(16'hff00, 2, 16'hfffb);
      wr(tpc_pkg::REG_ST_LAG, 32'h0000_0001);
      per(1);
      sp(16'h1000, 1, 16'h0000);
      sp(16'h1000, 1, 16'h0002);
      wr(tpc_pkg::REG_ST_COMP, 32'h0000_0000);
      wr(tpc_pkg::REG_ST_LAG, 32'h0000_0000);
      wr(tpc_pkg::REG_LH_COMP, 32'h0000_0006);
      sp(16'h0108, 2, 16'h0006);
      sp(16'h00f8, 2, 16'hfffa);
      sp(16'h0200, 2, 16'h0000);
      wr(tpc_pkg::REG_LH_LAG, 32'h0000_0001);
      per(1);
      sp(16'h0108, 1, 16'h0000);
      sp(16'h0108, 1, 16'h0003);
   endtask
   task automatic t_fault();
      // two sensors fitted here, so the threshold applies
      wr(tpc_pkg::REG_THRESH, 32'h0000_0010);
      skew <= 16'sh0010;
      per(2);
      chk({31'h0, fault}, 32'h0000_0000);
      skew <= 16'sh0011;
      per(2);
      chk({31'h0, fault}, 32'h0000_0001);
      rd(tpc_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0001);
      skew <= -16'sh0011;
      per(2);
      chk({31'h0, fault}, 32'h0000_0001);
      skew <= 16'sh0000;
      per(2);
      chk({31'h0, fault}, 32'h0000_0000);
   endtask
   task automatic t_cal();
      cal_lh <= 16'sh0040;
      cal_valid <= 1'b1;
      @(posedge sys_clk);
      cal_valid <= 1'b0;
      @(posedge sys_clk);
      chk({16'h0000, in_use}, 32'h0000_0040);
      wr(tpc_pkg::REG_LH_CFG, 32'h0000_0300);
      rd(tpc_pkg::REG_LH_USE, 32'hffff_ffff, 32'h0000_0040);
      rd(tpc_pkg::REG_STATUS, 32'h0000_0002, 32'h0000_0002);
   endtask
   task automatic t_lead();
      // wide limit so the shaped error reaches the drive unclipped
      wr(tpc_pkg::REG_RES, 32'h0000_ffff);
      wr(tpc_pkg::REG_KP_UP, 32'h0000_0100);
      wr(tpc_pkg::REG_LEAD, 32'h0000_0001);
      sp(16'h0200, 1, 16'h02fa);
      wr(tpc_pkg::REG_LAG, 32'h0000_0001);
      sp(16'h0200, 1, 16'h021f);
      // out of band the limp-home value holds where the last band visit left it
      rd(tpc_pkg::REG_LH_VOLT, 32'hffff_ffff, 32'h0000_0005);
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         mismatches++;
         end_sim();
      end
   end
   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_regs();
      t_side();
      t_pid();
      t_comp();
      t_fault();
      t_lead();
      t_cal();
      end_sim();
   end
endmodule
